// ### rtl/tms_timer16.sv
// 16-bit timer/counter: normal, clear-on-compare and fast pwm sequencing
// Notes on behaviour
// - mode 0 counts up, wraps at max
// - normal mode overflow flag set on max wrap
// - counter writes accepted any time
// - modes 4/12 clear on TOP match
// - clear-on-compare sets TOP register's flag
// - unbuffered TOP; late TOP wraps first
// - action 1 toggles output A on match
// - toggle frequency follows prescale and compare
// - clear-on-compare overflow on max wrap
// - modes 5,6,7,14,15 single slope
// - pwm: level at match, opposite at TOP
// - pwm TOP per mode, clear after TOP
// - pwm overflow and TOP flag together
// - pwm compare flags set on equality
// - fixed TOP masks compare writes
// - capture TOP unbuffered, may wrap
// - pwm compare A buffered, loaded at TOP
// - counting depends on mode field, not action field
// - action field: set/clear/toggle or polarity
// - pin driven only when direction is one
// - action zero leaves output untouched
// - buffering only in pwm modes
// - counter write blocks next tick's matches
//
// The register addresses and register access over APB were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
`include "tms_map.svh"

module tms_timer16 #(
	parameter int CNT_W = 16,
	parameter int NCH = 2
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic [NCH-1:0] compare_output,
	output logic [NCH-1:0] compare_output_oe
);
	import tms_pkg::*;

	// ****************************************
	// functions
	// ****************************************

	// single-slope pwm modes
	function automatic logic is_pwm(input logic [3:0] m);
		case (m)
			TMS_FAST_8, TMS_FAST_9, TMS_FAST_10, TMS_FAST_CAPT, TMS_FAST_A: is_pwm = 1'b1;
			default: is_pwm = 1'b0;
		endcase
	endfunction

	// clear-on-compare modes
	function automatic logic is_ctc(input logic [3:0] m);
		case (m)
			TMS_CTC_A, TMS_CTC_CAPT: is_ctc = 1'b1;
			default: is_ctc = 1'b0;
		endcase
	endfunction

	// bits a compare value may hold under a fixed top
	function automatic logic [15:0] top_mask(input logic [3:0] m);
		case (m)
			TMS_FAST_8: top_mask = `TMS_TOP_8;
			TMS_FAST_9: top_mask = `TMS_TOP_9;
			TMS_FAST_10: top_mask = `TMS_TOP_10;
			default: top_mask = `TMS_MAX;
		endcase
	endfunction

	// prescaler terminal count; zero select stops the clock
	function automatic logic [9:0] div_limit(input logic [2:0] s);
		case (s)
			3'h1: div_limit = `TMS_DIV1;
			3'h2: div_limit = `TMS_DIV8;
			3'h3: div_limit = `TMS_DIV64;
			3'h4: div_limit = `TMS_DIV256;
			default: div_limit = `TMS_DIV1024;
		endcase
	endfunction

	// ****************************************
	// state
	// ****************************************
	tms_ctrl_s ctrl_reg;
	tms_flags_s flags_reg;
	logic [CNT_W-1:0] cnt_reg;
	logic [CNT_W-1:0] capt_reg;
	logic [CNT_W-1:0] cmp_buf_reg [NCH];
	logic [CNT_W-1:0] cmp_act_reg [NCH];
	logic [NCH-1:0] oc_reg;
	logic block_reg;
	logic [9:0] pre_reg;
	logic tick_reg;
	logic [31:0] prdata_reg;
	logic pready_reg;
	logic pslverr_reg;
	logic [NCH-1:0] pin_reg;
	logic [NCH-1:0] pin_oe_reg;

	logic [3:0] mode;
	logic pwm;
	logic clear_on_compare_mode;
	logic [CNT_W-1:0] top;
	logic top_hit;
	logic wr_cyc;
	logic [NCH-1:0] match;
	logic [CNT_W-1:0] wr_val;
	logic [1:0] act [NCH];

	// ****************************************
	// apb slave
	// ****************************************

	// a write lands on the last access edge, when pready is high
	assign wr_cyc = psel & penable & pready_reg & pwrite;
	assign wr_val = pwdata[CNT_W-1:0];

	// one wait-free access phase: answer is staged during setup
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_reg <= 1'b0;
		end else begin
			pready_reg <= psel & ~penable;
		end
	end

	// read data and error are latched in the setup cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_reg <= 32'h0000_0000;
			pslverr_reg <= 1'b0;
		end else if (psel & ~penable) begin
			pslverr_reg <= 1'b0;
			case (paddr)
				`TMS_OFF_CTRL: prdata_reg <= {18'h00000, ctrl_reg};
				`TMS_OFF_COUNT: prdata_reg <= {16'h0000, cnt_reg};
				`TMS_OFF_CMPA: prdata_reg <= {16'h0000, cmp_buf_reg[0]};
				`TMS_OFF_CMPB: prdata_reg <= {16'h0000, cmp_buf_reg[1]};
				`TMS_OFF_CAPT: prdata_reg <= {16'h0000, capt_reg};
				`TMS_OFF_FLAGS: prdata_reg <= {28'h0000000, flags_reg};
				`TMS_OFF_STATUS: prdata_reg <= {28'h0000000, oc_reg, 1'b0, block_reg};
				default: begin
					prdata_reg <= 32'h0000_0000;
					pslverr_reg <= 1'b1;
				end
			endcase
		end else begin
			pslverr_reg <= 1'b0; // the error stands only alongside pready
		end
	end

	// control register; mode changes take effect at once
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_reg <= `TMS_CTRL_RST;
		end else if (wr_cyc && paddr == `TMS_OFF_CTRL) begin
			ctrl_reg <= pwdata[`TMS_CTRL_W-1:0];
		end
	end

	// capture register acting as top is never buffered
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			capt_reg <= `TMS_CNT_RST;
		end else if (wr_cyc && paddr == `TMS_OFF_CAPT) begin
			capt_reg <= wr_val;
		end
	end

	// ****************************************
	// prescaler
	// ****************************************

	// tick pulses once per prescaled period; disable or stop holds it low
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pre_reg <= 10'h000;
			tick_reg <= 1'b0;
		end else if (!ctrl_reg.timer_enable || ctrl_reg.prescale_select == 3'h0) begin
			pre_reg <= 10'h000;
			tick_reg <= 1'b0;
		end else if (pre_reg >= div_limit(ctrl_reg.prescale_select)) begin
			pre_reg <= 10'h000;
			tick_reg <= 1'b1;
		end else begin
			pre_reg <= pre_reg + 10'h001;
			tick_reg <= 1'b0;
		end
	end

	// ****************************************
	// top selection and matching
	// ****************************************
	assign mode = ctrl_reg.waveform_mode_select;
	assign pwm = is_pwm(mode);
	assign clear_on_compare_mode = is_ctc(mode);

	// top source follows the mode field alone
	always_comb begin
		case (mode)
			TMS_CTC_A, TMS_FAST_A: top = cmp_act_reg[0];
			TMS_CTC_CAPT, TMS_FAST_CAPT: top = capt_reg;
			TMS_FAST_8: top = `TMS_TOP_8;
			TMS_FAST_9: top = `TMS_TOP_9;
			TMS_FAST_10: top = `TMS_TOP_10;
			default: top = `TMS_MAX;
		endcase
	end

	// a counter write masks every match on the next tick
	assign top_hit = (cnt_reg == top) & ~block_reg;

	// ****************************************
	// counter
	// ****************************************

	// software write wins over a tick in the same cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_reg <= `TMS_CNT_RST;
		end else if (wr_cyc && paddr == `TMS_OFF_COUNT) begin
			cnt_reg <= wr_val;
		end else if (tick_reg) begin
			if ((clear_on_compare_mode || pwm) && top_hit) begin
				cnt_reg <= `TMS_CNT_RST;
			end else begin
				cnt_reg <= cnt_reg + 16'h0001;
			end
		end
	end

	// blocking holds until a tick consumes it, even when stopped
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			block_reg <= 1'b0;
		end else if (wr_cyc && paddr == `TMS_OFF_COUNT) begin
			block_reg <= 1'b1;
		end else if (tick_reg) begin
			block_reg <= 1'b0;
		end
	end

	// ****************************************
	// flags, write one to clear, a set wins
	// ****************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			flags_reg <= 4'h0;
		end else begin
			if (wr_cyc && paddr == `TMS_OFF_FLAGS) begin
				flags_reg <= flags_reg & ~pwdata[3:0];
			end
			if (tick_reg) begin
				if (pwm ? top_hit : cnt_reg == `TMS_MAX) begin
					flags_reg.overflow_flag <= 1'b1;
				end
				if (match[0]) begin
					flags_reg.compare_flag_a <= 1'b1;
				end
				if (match[1]) begin
					flags_reg.compare_flag_b <= 1'b1;
				end
				if (top_hit && (mode == TMS_CTC_CAPT || mode == TMS_FAST_CAPT)) begin
					flags_reg.capture_flag <= 1'b1;
				end
			end
		end
	end

	// ****************************************
	// per-channel compare and output logic
	// ****************************************
	generate
		for (genvar i = 0; i < NCH; i++) begin : g_ch
			assign act[i] = (i == 0) ? ctrl_reg.compare_output_action_a :
				ctrl_reg.compare_output_action_b;

			// equality against the active value; a value above top matches only once the count is already past top
			assign match[i] = (cnt_reg == cmp_act_reg[i]) & ~block_reg;

			// pwm writes go to the buffer, other modes write straight through
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					cmp_buf_reg[i] <= `TMS_CNT_RST;
					cmp_act_reg[i] <= `TMS_CNT_RST;
				end else begin
					if (wr_cyc && paddr == ((i == 0) ? `TMS_OFF_CMPA : `TMS_OFF_CMPB)) begin
						cmp_buf_reg[i] <= wr_val & top_mask(mode);
						if (!pwm) begin
							cmp_act_reg[i] <= wr_val & top_mask(mode);
						end
					end
					if (tick_reg && pwm && top_hit) begin
						cmp_act_reg[i] <= cmp_buf_reg[i];
					end
				end
			end

			// internal output level; the action field never touches the count
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					oc_reg[i] <= 1'b0;
				end else if (tick_reg) begin
					if (pwm) begin
						case (act[i])
							2'h1: begin
								if (i == 0 && mode == TMS_FAST_A && match[i]) begin
									oc_reg[i] <= ~oc_reg[i];
								end
							end
							2'h2: begin
								if (match[i]) begin
									oc_reg[i] <= 1'b1;
								end else if (top_hit) begin
									oc_reg[i] <= 1'b0;
								end
							end
							2'h3: begin
								if (match[i]) begin
									oc_reg[i] <= 1'b0;
								end else if (top_hit) begin
									oc_reg[i] <= 1'b1;
								end
							end
							default: oc_reg[i] <= oc_reg[i];
						endcase
					end else if (match[i]) begin
						case (act[i])
							2'h1: oc_reg[i] <= ~oc_reg[i];
							2'h2: oc_reg[i] <= 1'b0;
							2'h3: oc_reg[i] <= 1'b1;
							default: oc_reg[i] <= oc_reg[i];
						endcase
					end
				end
			end

			// pin shows the level only while its direction bit selects output
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					pin_reg[i] <= 1'b0;
					pin_oe_reg[i] <= 1'b0;
				end else begin
					pin_oe_reg[i] <= (i == 0) ? ctrl_reg.pin_direction_bit_a :
						ctrl_reg.pin_direction_bit_b;
					pin_reg[i] <= oc_reg[i] & ((i == 0) ? ctrl_reg.pin_direction_bit_a :
						ctrl_reg.pin_direction_bit_b);
				end
			end
		end
	endgenerate

	// ****************************************
	// outputs
	// ****************************************
	assign prdata = prdata_reg;
	assign pready = pready_reg;
	assign pslverr = pslverr_reg;
	assign compare_output = pin_reg;
	assign compare_output_oe = pin_oe_reg;

endmodule // tms_timer16
`default_nettype wire

// ### inc/tms_map.svh
// register map, field positions, reset values and timing counts of the timer
`ifndef TMS_MAP_SVH
`define TMS_MAP_SVH

// ****************************************
// register byte offsets
// ****************************************
`define TMS_OFF_CTRL 8'h00
`define TMS_OFF_COUNT 8'h04
`define TMS_OFF_CMPA 8'h08
`define TMS_OFF_CMPB 8'h0c
`define TMS_OFF_CAPT 8'h10
`define TMS_OFF_FLAGS 8'h14
`define TMS_OFF_STATUS 8'h18

// ****************************************
// field positions
// ****************************************
`define TMS_CTRL_W 14
`define TMS_FLAG_OVF 0
`define TMS_FLAG_CMPA 1
`define TMS_FLAG_CMPB 2
`define TMS_FLAG_CAPT 3

// ****************************************
// reset values and fixed tops
// ****************************************
`define TMS_CTRL_RST 14'h0000
`define TMS_CNT_RST 16'h0000
`define TMS_MAX 16'hffff
`define TMS_TOP_8 16'h00ff
`define TMS_TOP_9 16'h01ff
`define TMS_TOP_10 16'h03ff

// ****************************************
// prescaler terminal counts (divisor - 1)
// ****************************************
`define TMS_DIV1 10'h000
`define TMS_DIV8 10'h007
`define TMS_DIV64 10'h03f
`define TMS_DIV256 10'h0ff
`define TMS_DIV1024 10'h3ff

`endif

// ### inc/tms_pkg.sv
// types shared by the timer block
package tms_pkg;

	// waveform modes that the block decodes
	typedef enum logic [3:0] {
		TMS_NORMAL = 4'h0,
		TMS_CTC_A = 4'h4,
		TMS_FAST_8 = 4'h5,
		TMS_FAST_9 = 4'h6,
		TMS_FAST_10 = 4'h7,
		TMS_CTC_CAPT = 4'hc,
		TMS_FAST_CAPT = 4'he,
		TMS_FAST_A = 4'hf
	} tms_mode_e;

	// control word as software writes it
	typedef struct packed {
		logic [2:0] prescale_select;
		logic timer_enable;
		logic pin_direction_bit_b;
		logic pin_direction_bit_a;
		logic [1:0] compare_output_action_b;
		logic [1:0] compare_output_action_a;
		logic [3:0] waveform_mode_select;
	} tms_ctrl_s;

	// sticky event flags
	typedef struct packed {
		logic capture_flag;
		logic compare_flag_b;
		logic compare_flag_a;
		logic overflow_flag;
	} tms_flags_s;

endpackage

// ### test/tms_timer16_asserts.sv
// concurrent checks on the timer's bus and pin ports
`timescale 1ns/100ps
`default_nettype none
`include "tms_map.svh"
module tms_timer16_asserts #(
	parameter int CNT_W = 16,
	parameter int NCH = 2
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic [NCH-1:0] compare_output,
	input wire logic [NCH-1:0] compare_output_oe
);
	import tms_pkg::*;
	// ****
	// bus handshake and pin gating
	// ****
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// a setup cycle, then the access cycle that completes it
	sequence s_setup;
		psel && !penable;
	endsequence
	sequence s_done;
		psel && penable && pready;
	endsequence
	sequence s_ctrl_wr;
		s_done ##0 (pwrite && paddr == `TMS_OFF_CTRL);
	endsequence
	chk_ready_follows: assert property (s_setup |=> pready)
		else $error("no ready after setup");
	chk_ready_scoped: assert property (pready |-> psel && penable)
		else $error("ready outside access");
	chk_ready_single: assert property (pready |=> !pready)
		else $error("ready held too long");
	chk_err_scoped: assert property (pslverr |-> pready)
		else $error("error without ready");
	chk_unmapped_err: assert property (s_done ##0 paddr > `TMS_OFF_STATUS |-> pslverr)
		else $error("unmapped access not refused");
	chk_mapped_clean: assert property (s_done ##0 (paddr <= `TMS_OFF_STATUS
		&& paddr[1:0] == 2'b00) |-> !pslverr) else $error("mapped access refused");
	chk_err_read_zero: assert property (pslverr && !pwrite |-> prdata == 32'h0)
		else $error("refused read not zero");
	chk_upper_zero: assert property (pready && !pwrite |-> prdata[31:16] == 16'h0)
		else $error("upper read bits set");
	chk_pin_gated: assert property ((compare_output & ~compare_output_oe) == '0)
		else $error("pin driven while not output");
	// the pin enable trails the direction bits by one register stage
	chk_dir_follow: assert property (s_ctrl_wr |-> ##2 compare_output_oe == $past(pwdata[9:8], 2))
		else $error("pin enable not following direction");
endmodule // tms_timer16_asserts

bind tms_timer16 tms_timer16_asserts #(.CNT_W(CNT_W), .NCH(NCH)) chk (.pclk(pclk),
	.presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
	.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.compare_output(compare_output), .compare_output_oe(compare_output_oe));
`default_nettype wire

// ### test/tms_pin_load.sv
// load on the two compare pins, pulled down when released
`timescale 1ns/100ps
`default_nettype none
module tms_pin_load (
	input wire logic pclk,
	input wire logic [1:0] drive,
	input wire logic [1:0] oe,
	output logic [1:0] level,
	output var logic [15:0] rises_a
);
	logic prev_a = 1'b0;
	// a released pin sinks to the pull-down, never keeps its last value
	assign level = drive & oe;
	// rising edges of pin a, seen on the clock
	initial rises_a = 16'h0000;
	always @(posedge pclk) begin
		prev_a <= level[0];
		if (level[0] && !prev_a) begin
			rises_a <= rises_a + 16'h0001;
		end
	end
endmodule // tms_pin_load
`default_nettype wire

// ### test/tms_timer16_bench.sv
// self-checking bench for the 16-bit timer
`timescale 1ns/100ps
`default_nettype none
`include "tms_map.svh"
module tms_timer16_bench;
	import tms_pkg::*;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic [1:0] pin;
	logic [1:0] pin_oe;
	logic [1:0] level;
	logic [15:0] rises;
	logic [31:0] rv;
	logic re;
	int err_total = 0;
	int compares = 0;
	// ****
	// clock, design and load
	// ****
	always #25 pclk = ~pclk;
	tms_timer16 uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .compare_output(pin), .compare_output_oe(pin_oe));
	tms_pin_load load (.pclk(pclk), .drive(pin), .oe(pin_oe), .level(level), .rises_a(rises));
	task automatic wrap_up;
		if (err_total == 0 && compares > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			err_total++;
			$display("MISMATCH %0t got %h want %h", $time, got, exp);
		end
	endtask
	task automatic chk_in(input logic [31:0] got, input logic [31:0] lo, input logic [31:0] hi);
		compares++;
		if ((got >= lo && got <= hi) !== 1'b1) begin
			err_total++;
			$display("MISMATCH %0t got %h out of range", $time, got);
		end
	endtask
	// one bus transfer; waits for ready, bounded
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 16);
		if (pready !== 1'b1) begin
			err_total++;
			wrap_up();
		end
		rv = prdata;
		re = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// control word at prescale one; enable bit left to run
	function automatic logic [31:0] cw(input logic [3:0] m, input logic [1:0] act, input logic dir);
		return {18'h0, 3'h1, 1'b0, 1'b0, dir, 2'b00, act, m};
	endfunction
	task automatic run(input logic [31:0] c, input int n);
		apb(1'b1, `TMS_OFF_CTRL, c | 32'h400);
		repeat (n) @(posedge pclk);
		apb(1'b1, `TMS_OFF_CTRL, c);
	endtask
	// ****
	// scenarios
	// ****
	task automatic t_reset;
		apb(1'b0, `TMS_OFF_CTRL, 32'h0);
		chk(rv, 32'h0);
		apb(1'b0, `TMS_OFF_COUNT, 32'h0);
		chk(rv, 32'h0);
		apb(1'b1, 8'h1c, 32'hffff);
		chk({31'h0, re}, 32'h1);
		apb(1'b0, 8'h1c, 32'h0);
		chk({31'h0, re}, 32'h1);
		chk(rv, 32'h0);
	endtask
	task automatic t_mask;
		logic [31:0] exp [3] = '{32'h34, 32'h34, 32'h234};
		for (int i = 0; i < 3; i++) begin
			apb(1'b1, `TMS_OFF_CTRL, cw(4'h5 + i[3:0], 2'b00, 1'b0));
			apb(1'b1, `TMS_OFF_CMPA, 32'h1234);
			apb(1'b0, `TMS_OFF_CMPA, 32'h0);
			chk(rv, exp[i]);
		end
	endtask
	// start just below each mode's top; it must wrap, and flag in every mode but 4 and 12
	task automatic t_modes;
		logic [3:0] m [8] = '{4'h0, 4'h4, 4'hc, 4'h5, 4'h6, 4'h7, 4'he, 4'hf};
		logic [15:0] top [8] = '{16'hffff, 16'hf, 16'hf, 16'hff, 16'h1ff, 16'h3ff, 16'hf, 16'hf};
		logic clear_on_compare_mode;
		logic capt;
		for (int i = 0; i < 8; i++) begin
			clear_on_compare_mode = (m[i] == 4'h4 || m[i] == 4'hc);
			capt = (m[i] == 4'hc || m[i] == 4'he);
			apb(1'b1, `TMS_OFF_CTRL, cw(m[i], 2'b00, 1'b0));
			apb(1'b1, `TMS_OFF_CMPA, 32'hf);
			apb(1'b1, `TMS_OFF_CAPT, 32'hf);
			apb(1'b1, `TMS_OFF_COUNT, {16'h0, top[i] - 16'h4});
			apb(1'b1, `TMS_OFF_FLAGS, 32'hf);
			run(cw(m[i], 2'b00, 1'b0), 20);
			apb(1'b0, `TMS_OFF_COUNT, 32'h0);
			chk_in(rv, 32'h0, 32'h1f);
			apb(1'b0, `TMS_OFF_FLAGS, 32'h0);
			chk(rv & 32'h9, {28'h0, capt, 2'b00, !clear_on_compare_mode});
		end
	endtask
	// output actions, pin direction and pwm polarity, judged at the load
	task automatic t_waves;
		logic [6:0] c [7] = '{7'h54, 7'h64, 7'h74, 7'h44, 7'h14, 7'h6e, 7'h7e};
		int lo [7] = '{9, 0, 1, 0, 0, 4, 4};
		int hi [7] = '{11, 0, 1, 0, 0, 6, 6};
		int lv [7] = '{2, 0, 1, 1, 0, 2, 2};
		logic [15:0] r0;
		for (int i = 0; i < 7; i++) begin
			apb(1'b1, `TMS_OFF_CTRL, cw(c[i][3:0], c[i][5:4], c[i][6]));
			apb(1'b1, `TMS_OFF_CMPA, 32'h3);
			apb(1'b1, `TMS_OFF_CAPT, 32'hf);
			apb(1'b1, `TMS_OFF_COUNT, 32'h0);
			r0 = rises;
			run(cw(c[i][3:0], c[i][5:4], c[i][6]), 80);
			chk_in({16'h0, rises - r0}, lo[i], hi[i]);
			if (lv[i] != 2) chk({31'h0, level[0]}, lv[i]);
		end
	endtask
	// a blocked or late match leaves the counter running past top
	task automatic t_block(input logic [15:0] start, input logic [15:0] cmp);
		apb(1'b1, `TMS_OFF_CTRL, cw(4'h4, 2'b00, 1'b0));
		apb(1'b1, `TMS_OFF_CMPA, {16'h0, cmp});
		apb(1'b1, `TMS_OFF_COUNT, {16'h0, start});
		apb(1'b1, `TMS_OFF_FLAGS, 32'hf);
		run(cw(4'h4, 2'b00, 1'b0), 20);
		apb(1'b0, `TMS_OFF_COUNT, 32'h0);
		chk_in(rv, {16'h0, start} + 32'h1, 32'hffff);
		apb(1'b0, `TMS_OFF_FLAGS, 32'h0);
		chk(rv & 32'h2, 32'h0);
	endtask
	// channel b sets its own pin, flag and status level at its match
	task automatic t_chan_b;
		apb(1'b1, `TMS_OFF_CTRL, 32'hac4);
		apb(1'b1, `TMS_OFF_CMPA, 32'hf);
		apb(1'b1, `TMS_OFF_CMPB, 32'h2);
		apb(1'b1, `TMS_OFF_COUNT, 32'h0);
		apb(1'b1, `TMS_OFF_FLAGS, 32'hf);
		run(32'hac4, 20);
		chk({31'h0, level[1]}, 32'h1);
		apb(1'b0, `TMS_OFF_FLAGS, 32'h0);
		chk(rv & 32'h4, 32'h4);
		apb(1'b0, `TMS_OFF_STATUS, 32'h0);
		chk(rv & 32'h9, 32'h8);
	endtask
	initial begin
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		t_reset();
		t_mask();
		t_modes();
		t_waves();
		t_block(16'h5, 16'h5);
		t_block(16'h100, 16'h10);
		t_chan_b();
		wrap_up();
	end
endmodule // tms_timer16_bench
`default_nettype wire
